// *** design/ormt_top.sv ***
// output reference, margin and telemetry logic of the step-down module
//
// Contract
// - trim shifts reference by signed -64..+63 steps of 1.953 mV.
// - store-all command saves trim to nonvolatile storage.
// - separate signed margin-high and margin-low codes, -64 to 31.
// - operation command picks margin none, high or low.
// - reference = vout times scale plus trim plus gated margins.
// - reference stays inside 0.35 V to 1.65 V dac span.
// - loop scale accepts only 1 (default) or 0.5.
// - fault pulls shared line low; low shared line stops switching.
// - 50% sync clock; master locks rising edge, slave falling edge.
// - current sampled at middle of low-side drive interval.
// - current digitized, averaged, kept in read-only register.
// - sinking current reported as zero.
// - output voltage digitized, averaged, kept in read-only register.
// - calibration offset corrects current for telemetry and overcurrent.
// - operation bit 7 turns conversion on and off.
`timescale 1ns/1ps
`include "ormt_params.svh"
module ormt_top #(
  parameter int ADC_W = 12,
  parameter int AVG_LOG2 = 4,
  parameter int LS_W = 10
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdWData,
  output logic [15:0] cmdRData,
  output logic [9:0] errorAmpReference,
  output logic convEnable,
  output logic switchEnable,
  input wire logic faultIn,
  input wire logic sharedCompFaultLineIn,
  output logic sharedCompFaultLineOut,
  output logic sharedCompFaultLineOeN,
  input wire logic syncPin,
  input wire logic slaveStrap,
  output logic phaseLock,
  input wire logic lowSideDrive,
  output logic sampleCurrent,
  input wire logic adcIValid,
  input wire logic [ADC_W-1:0] adcIData,
  input wire logic adcVValid,
  input wire logic [ADC_W-1:0] adcVData,
  output logic [ADC_W-1:0] currentCorrected,
  output logic nvmStore,
  output logic [6:0] nvmTrim
);
  localparam int REF_MIN = (`ORMT_DAC_MIN_UV + `ORMT_LSB_UV - 1)
                           / `ORMT_LSB_UV;
  localparam int REF_MAX = `ORMT_DAC_MAX_UV / `ORMT_LSB_UV;

  if (ADC_W < 4 || ADC_W > 16 || LS_W < 2 || LS_W > 16)
  begin : g_chk
    $error("ormt_top: unsupported adc or interval counter width");
  end

  // ****************************************
  // command registers
  // ****************************************
  ormt_avg_if #(.W(ADC_W)) iCh ();
  ormt_avg_if #(.W(ADC_W)) vCh ();
  logic [7:0] opReg, next_opReg;
  logic [9:0] voutReg, next_voutReg;
  logic signed [6:0] trimReg, next_trimReg;
  logic signed [7:0] mhiReg, next_mhiReg;
  logic signed [7:0] mloReg, next_mloReg;
  logic scaleHalf, next_scaleHalf;
  logic [ADC_W-1:0] calReg, next_calReg;
  logic [15:0] next_cmdRData;
  logic next_nvmStore;

  function automatic logic signed [7:0] marginSat(input logic [15:0] d);
    if ($signed(d) > `ORMT_MARGIN_MAX)
      return 8'(`ORMT_MARGIN_MAX);
    if ($signed(d) < `ORMT_MARGIN_MIN)
      return 8'(`ORMT_MARGIN_MIN);
    return d[7:0];
  endfunction : marginSat

  always_comb
  begin
    next_opReg = opReg;
    next_voutReg = voutReg;
    next_trimReg = trimReg;
    next_mhiReg = mhiReg;
    next_mloReg = mloReg;
    next_scaleHalf = scaleHalf;
    next_calReg = calReg;
    next_nvmStore = 1'b0;
    next_cmdRData = cmdRData;
    if (cmdWrite)
    begin
      case (cmdCode)
        `ORMT_CMD_OPERATION: next_opReg = cmdWData[7:0];
        `ORMT_CMD_VOUT: next_voutReg = cmdWData[9:0];
        `ORMT_CMD_TRIM: next_trimReg = cmdWData[6:0];
        `ORMT_CMD_MARGIN_HIGH: next_mhiReg = marginSat(cmdWData);
        `ORMT_CMD_MARGIN_LOW: next_mloReg = marginSat(cmdWData);
        `ORMT_CMD_CAL_OFFSET: next_calReg = cmdWData[ADC_W-1:0];
        `ORMT_CMD_STORE_ALL: next_nvmStore = 1'b1;
        `ORMT_CMD_SCALE:
        begin
          if (cmdWData == `ORMT_SCALE_HALF)
            next_scaleHalf = 1'b1;
          else if (cmdWData == `ORMT_SCALE_UNITY)
            next_scaleHalf = 1'b0;
        end
        default: ;
      endcase
    end
    if (cmdRead)
    begin
      case (cmdCode)
        `ORMT_CMD_OPERATION: next_cmdRData = {8'h00, opReg};
        `ORMT_CMD_VOUT: next_cmdRData = {6'h00, voutReg};
        `ORMT_CMD_TRIM: next_cmdRData = 16'($signed(trimReg));
        `ORMT_CMD_MARGIN_HIGH: next_cmdRData = 16'($signed(mhiReg));
        `ORMT_CMD_MARGIN_LOW: next_cmdRData = 16'($signed(mloReg));
        `ORMT_CMD_SCALE: next_cmdRData = {15'h0000, scaleHalf};
        `ORMT_CMD_CAL_OFFSET: next_cmdRData = 16'(calReg);
        `ORMT_CMD_READ_IOUT: next_cmdRData = 16'(iCh.average);
        `ORMT_CMD_READ_VOUT: next_cmdRData = 16'(vCh.average);
        default: next_cmdRData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      opReg <= `ORMT_OP_RESET;
      voutReg <= `ORMT_VOUT_RESET;
      trimReg <= `ORMT_TRIM_RESET;
      mhiReg <= `ORMT_MARGIN_RESET;
      mloReg <= `ORMT_MARGIN_RESET;
      scaleHalf <= 1'b0;
      calReg <= `ORMT_CAL_RESET;
      nvmStore <= 1'b0;
      nvmTrim <= `ORMT_TRIM_RESET;
      cmdRData <= 16'h0000;
    end
    else
    begin
      opReg <= next_opReg;
      voutReg <= next_voutReg;
      trimReg <= next_trimReg;
      mhiReg <= next_mhiReg;
      mloReg <= next_mloReg;
      scaleHalf <= next_scaleHalf;
      calReg <= next_calReg;
      nvmStore <= next_nvmStore;
      nvmTrim <= next_nvmStore ? trimReg : nvmTrim;
      cmdRData <= next_cmdRData;
    end
  end

  // ****************************************
  // reference sum and clamp
  // ****************************************
  ormt_pkg::ormt_margin_t margin;
  logic signed [12:0] refSum;
  logic [9:0] next_ref;

  always_comb
  begin
    margin = ormt_pkg::ormtMarginOf(opReg[`ORMT_OP_MHI_BIT],
                                    opReg[`ORMT_OP_MLO_BIT]);
    refSum = $signed({3'b000, scaleHalf ? {1'b0, voutReg[9:1]} : voutReg})
             + 13'(trimReg);
    case (margin)
      ormt_pkg::ORMT_MRG_HIGH: refSum = refSum + 13'(mhiReg);
      ormt_pkg::ORMT_MRG_LOW: refSum = refSum + 13'(mloReg);
      default: ;
    endcase
    if (refSum < REF_MIN)
      next_ref = 10'(REF_MIN);
    else if (refSum > REF_MAX)
      next_ref = 10'(REF_MAX);
    else
      next_ref = refSum[9:0];
  end

  // ****************************************
  // pins, parallel operation, sampling point
  // ****************************************
  logic [1:0] shS, syS, lsS, stS;
  logic syPrev, lsPrev;
  logic [LS_W-1:0] lsCnt, next_lsCnt, lsLen, next_lsLen;

  always_comb
  begin
    next_lsCnt = lsCnt;
    next_lsLen = lsLen;
    if (lsS[1])
      next_lsCnt = LS_W'(lsCnt + 1'b1);
    else
      next_lsCnt = '0;
    if (lsPrev && !lsS[1])
      next_lsLen = lsCnt; // length of the last low-side interval
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      errorAmpReference <= 10'(REF_MIN);
      shS <= 2'b11;
      syS <= 2'b00;
      lsS <= 2'b00;
      stS <= 2'b00;
      syPrev <= 1'b0;
      lsPrev <= 1'b0;
      lsCnt <= '0;
      lsLen <= '0;
      sharedCompFaultLineOeN <= 1'b1;
    end
    else
    begin
      errorAmpReference <= next_ref;
      shS <= {shS[0], sharedCompFaultLineIn};
      syS <= {syS[0], syncPin};
      lsS <= {lsS[0], lowSideDrive};
      stS <= {stS[0], slaveStrap};
      syPrev <= syS[1];
      lsPrev <= lsS[1];
      lsCnt <= next_lsCnt;
      lsLen <= next_lsLen;
      sharedCompFaultLineOeN <= !faultIn;
    end
  end

  assign sharedCompFaultLineOut = 1'b0;
  assign convEnable = opReg[`ORMT_OP_ON_BIT];
  assign switchEnable = convEnable && shS[1] && !faultIn;
  assign phaseLock = stS[1] ? (syPrev && !syS[1])
                            : (!syPrev && syS[1]);
  assign sampleCurrent = lsS[1] && (lsCnt == (lsLen >> 1));

  // ****************************************
  // telemetry channels
  // ****************************************
  assign iCh.sampleValid = adcIValid;
  assign iCh.sample = adcIData;
  assign iCh.offset = calReg;
  assign vCh.sampleValid = adcVValid;
  assign vCh.sample = adcVData;
  assign vCh.offset = '0;
  assign currentCorrected = iCh.corrected;

  ormt_avg #(.W(ADC_W), .LOG2N(AVG_LOG2)) uCur (.mclk(mclk), .srst(srst),
                                                 .ch(iCh));
  ormt_avg #(.W(ADC_W), .LOG2N(AVG_LOG2)) uVolt (.mclk(mclk), .srst(srst),
                                                  .ch(vCh));

  // ****************************************
  // checks
  // ****************************************
  a_ref_span: assert property (@(posedge mclk) disable iff (srst)
    errorAmpReference >= REF_MIN && errorAmpReference <= REF_MAX)
    else $error("reference outside dac span");
  a_ref_sat: assert property (@(posedge mclk) disable iff (srst)
    refSum > REF_MAX |=> errorAmpReference == REF_MAX)
    else $error("reference did not saturate high");
  a_conv_bit: assert property (@(posedge mclk) disable iff (srst)
    cmdWrite && cmdCode == `ORMT_CMD_OPERATION
    |=> convEnable == $past(cmdWData[7]))
    else $error("conversion enable does not follow bit 7");
  a_fault_pull: assert property (@(posedge mclk) disable iff (srst)
    faultIn |=> !sharedCompFaultLineOeN)
    else $error("fault did not pull shared line");
  a_shared_stop: assert property (@(posedge mclk) disable iff (srst)
    !sharedCompFaultLineIn [*2] |-> ##1 !switchEnable)
    else $error("switching kept with shared line low");
  a_lock_edge: assert property (@(posedge mclk) disable iff (srst)
    phaseLock |-> (stS[1] ? $fell(syS[1]) : $rose(syS[1])))
    else $error("lock on the wrong sync edge");
  a_trim_store: assert property (@(posedge mclk) disable iff (srst)
    cmdWrite && cmdCode == `ORMT_CMD_STORE_ALL
    |=> nvmStore ##1 nvmTrim == $past(trimReg, 2))
    else $error("trim not stored");
  a_scale_only: assert property (@(posedge mclk) disable iff (srst)
    cmdWrite && cmdCode == `ORMT_CMD_SCALE && cmdWData > `ORMT_SCALE_HALF
    |=> $stable(scaleHalf))
    else $error("illegal loop scale accepted");
  a_margin_high: assert property (@(posedge mclk) disable iff (srst)
    opReg[`ORMT_OP_MHI_BIT] && refSum > REF_MIN && refSum < REF_MAX
    |=> $signed({3'b000, errorAmpReference}) == $past(refSum))
    else $error("margin high sum not applied");
  c_margin_high: cover property (@(posedge mclk) disable iff (srst)
    margin == ormt_pkg::ORMT_MRG_HIGH ##1 margin == ormt_pkg::ORMT_MRG_LOW);
  c_slave_lock: cover property (@(posedge mclk) disable iff (srst)
    stS[1] && phaseLock);
  c_mid_sample: cover property (@(posedge mclk) disable iff (srst)
    sampleCurrent ##[1:20] adcIValid);
endmodule : ormt_top

// *** design/ormt_params.svh ***
// constants for the output reference, margin and telemetry block
`ifndef ORMT_PARAMS_SVH
`define ORMT_PARAMS_SVH
// ****************************************
// command codes
// ****************************************
`define ORMT_CMD_OPERATION 8'h01
`define ORMT_CMD_STORE_ALL 8'h11
`define ORMT_CMD_VOUT 8'h21
`define ORMT_CMD_TRIM 8'h22
`define ORMT_CMD_SCALE 8'h29
`define ORMT_CMD_CAL_OFFSET 8'h39
`define ORMT_CMD_READ_VOUT 8'h8b
`define ORMT_CMD_READ_IOUT 8'h8c
`define ORMT_CMD_MARGIN_HIGH 8'hd5
`define ORMT_CMD_MARGIN_LOW 8'hd6
// ****************************************
// fields and reset values
// ****************************************
`define ORMT_OP_ON_BIT 7
`define ORMT_OP_MHI_BIT 5
`define ORMT_OP_MLO_BIT 4
`define ORMT_OP_RESET 8'h00
`define ORMT_VOUT_RESET 10'h100
`define ORMT_TRIM_RESET 7'h00
`define ORMT_MARGIN_RESET 8'h00
`define ORMT_CAL_RESET 12'h000
`define ORMT_SCALE_UNITY 16'h0000
`define ORMT_SCALE_HALF 16'h0001
`define ORMT_MARGIN_MAX 31
`define ORMT_MARGIN_MIN (-64)
// ****************************************
// reference scaling
// ****************************************
`define ORMT_LSB_UV 1953
`define ORMT_DAC_MIN_UV 350000
`define ORMT_DAC_MAX_UV 1650000
`endif

// *** design/ormt_pkg.sv ***
// types for the output reference, margin and telemetry block
package ormt_pkg;
  typedef enum logic [2:0] {
    ORMT_MRG_NONE = 3'h1,
    ORMT_MRG_HIGH = 3'h2,
    ORMT_MRG_LOW = 3'h4
  } ormt_margin_t;

  // margin state from the two operation bits; high wins if both set
  function automatic ormt_margin_t ormtMarginOf(input logic hi,
                                                input logic lo);
    if (hi)
      return ORMT_MRG_HIGH;
    else if (lo)
      return ORMT_MRG_LOW;
    return ORMT_MRG_NONE;
  endfunction : ormtMarginOf
endpackage : ormt_pkg

// *** design/ormt_avg_if.sv ***
// carrier between the telemetry core and one averaging channel
`timescale 1ns/1ps
interface ormt_avg_if #(parameter int W = 12);
  logic sampleValid;
  logic [W-1:0] sample;
  logic signed [W-1:0] offset;
  logic [W-1:0] corrected;
  logic [W-1:0] average;
  modport sink(input sampleValid, input sample, input offset,
               output corrected, output average);
  modport source(output sampleValid, output sample, output offset,
                 input corrected, input average);
endinterface : ormt_avg_if

// *** design/ormt_avg.sv ***
// offset correction, clip at zero and block averaging of adc samples
`timescale 1ns/1ps
module ormt_avg #(
  parameter int W = 12,
  parameter int LOG2N = 4
) (
  input wire logic mclk,
  input wire logic srst,
  ormt_avg_if.sink ch
);
  localparam int WA = W + LOG2N;

  if (W < 4 || W > 16 || LOG2N < 1 || LOG2N > 8)
  begin : g_chk
    $error("ormt_avg: unsupported width or averaging depth");
  end

  logic signed [W+1:0] corr;
  logic [W-1:0] clipped;
  logic [WA-1:0] acc;
  logic [WA-1:0] next_acc;
  logic [WA-1:0] sum;
  logic [LOG2N-1:0] cnt;
  logic [LOG2N-1:0] next_cnt;
  logic [W-1:0] average;
  logic [W-1:0] next_average;
  logic [W-1:0] corrected;
  logic [W-1:0] next_corrected;

  // ****************************************
  // correction and averaging
  // ****************************************
  always_comb
  begin
    corr = $signed({2'b00, ch.sample}) + $signed({{2{ch.offset[W-1]}},
                                                   ch.offset});
    if (corr < 0)
      clipped = '0;
    else if (corr[W])
      clipped = '1;
    else
      clipped = corr[W-1:0];
    sum = WA'(acc + {{LOG2N{1'b0}}, clipped});
    next_acc = acc;
    next_cnt = cnt;
    next_average = average;
    next_corrected = corrected;
    if (ch.sampleValid)
    begin
      next_corrected = clipped;
      next_cnt = LOG2N'(cnt + 1'b1);
      if (&cnt)
      begin
        next_average = sum[WA-1:LOG2N];
        next_acc = '0;
      end
      else
        next_acc = sum;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      acc <= '0;
      cnt <= '0;
      average <= '0;
      corrected <= '0;
    end
    else
    begin
      acc <= next_acc;
      cnt <= next_cnt;
      average <= next_average;
      corrected <= next_corrected;
    end
  end

  assign ch.average = average;
  assign ch.corrected = corrected;

  // ****************************************
  // checks
  // ****************************************
  a_neg_clip: assert property (@(posedge mclk) disable iff (srst)
    ch.sampleValid && corr < 0 |=> corrected == '0)
    else $error("negative current not reported as zero");
  a_avg_hold: assert property (@(posedge mclk) disable iff (srst)
    !ch.sampleValid |=> $stable(average))
    else $error("average changed without a sample");
endmodule : ormt_avg

// *** bench/ormt_peer.sv ***
// paralleled peer module and sync clock source seen by the block
`timescale 1ns/1ps
module ormt_peer #(
  parameter int HALF_NS = 200,
  parameter logic [6:0] PEER_ADDR = 7'h2a
) (
  input wire logic peerFault,
  output logic peerOeN,
  output logic syncPin
);
  // peer pulls the shared line low while it has a fault
  assign peerOeN = !peerFault;
  // free-running sync clock, equal high and low halves
  initial
  begin
    syncPin = 1'b0;
    forever #(HALF_NS) syncPin = !syncPin;
  end
endmodule : ormt_peer

// *** bench/tb_ormt_top.sv ***
// self-checking testbench of the reference, margin and telemetry block
`timescale 1ns/1ps
module tb_ormt_top;
  logic mclk, srst, cmdWrite, cmdRead, faultIn, slaveStrap;
  logic lowSideDrive, adcIValid, adcVValid, peerFault, peerOeN;
  logic syncPin, sharedLine, convEnable, switchEnable, phaseLock;
  logic sharedCompFaultLineOut, sharedCompFaultLineOeN;
  logic sampleCurrent, nvmStore;
  logic [7:0] cmdCode;
  logic [15:0] cmdWData, cmdRData, rv;
  logic [9:0] errorAmpReference;
  logic [11:0] adcIData, adcVData, currentCorrected;
  logic [6:0] nvmTrim;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // write code, write data, expected reference code
  localparam logic [33:0] STEPS [17] = '{
    {8'h22, 16'h0040, 10'h0c0}, {8'h22, 16'h003f, 10'h13f},
    {8'hd5, 16'h0005, 10'h13f}, {8'h01, 16'h0020, 10'h144},
    {8'hd6, 16'hfff6, 10'h144}, {8'h01, 16'h0010, 10'h135},
    {8'h01, 16'h0030, 10'h144}, {8'h22, 16'h0000, 10'h105},
    {8'hd5, 16'h0064, 10'h11f}, {8'h01, 16'h0010, 10'h0f6},
    {8'hd6, 16'hff38, 10'h0c0}, {8'h01, 16'h0000, 10'h100},
    {8'h29, 16'h0001, 10'h0b4}, {8'h29, 16'h0002, 10'h0b4},
    {8'h21, 16'h03ff, 10'h1ff}, {8'h29, 16'h0000, 10'h34c},
    {8'h21, 16'h0100, 10'h100}};

  // open-drain shared line with pull-up, either party may pull it low
  assign sharedLine = (sharedCompFaultLineOeN | sharedCompFaultLineOut)
                      & peerOeN;

  ormt_top dut (
    .mclk, .srst, .cmdWrite, .cmdRead, .cmdCode, .cmdWData, .cmdRData,
    .errorAmpReference, .convEnable, .switchEnable, .faultIn,
    .sharedCompFaultLineIn(sharedLine), .sharedCompFaultLineOut,
    .sharedCompFaultLineOeN, .syncPin, .slaveStrap, .phaseLock,
    .lowSideDrive, .sampleCurrent, .adcIValid, .adcIData, .adcVValid,
    .adcVData, .currentCorrected, .nvmStore, .nvmTrim
  );
  ormt_peer peer (.peerFault, .peerOeN, .syncPin);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    tick(1);
    cmdWrite = 1'b1;
    cmdCode = c;
    cmdWData = d;
    tick(1);
    cmdWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] c);
    tick(1);
    cmdRead = 1'b1;
    cmdCode = c;
    tick(1);
    cmdRead = 1'b0;
    rv = cmdRData;
  endtask : rd

  task automatic cref(input logic [9:0] ex);
    tick(2);
    chk(16'(errorAmpReference), 16'(ex), "reference");
  endtask : cref

  // sixteen adc strobes on the current or the voltage channel
  task automatic feed(input logic v, input logic [11:0] d);
    repeat (16)
    begin
      tick(1);
      adcIValid = !v;
      adcVValid = v;
      adcIData = d;
      adcVData = d;
      tick(1);
      adcIValid = 1'b0;
      adcVValid = 1'b0;
    end
  endtask : feed

  task automatic t_reset();
    cref(10'h100);
    chk(16'(convEnable), 16'h0000, "conv at reset");
    chk(16'(sharedCompFaultLineOeN), 16'h0001, "line at reset");
    rd(8'hd5);
    chk(rv, 16'h0000, "margin reset");
    rd(8'h21);
    chk(rv, 16'h0100, "vout reset");
    rd(8'h55);
    chk(rv, 16'h0000, "unmapped read");
  endtask : t_reset

  task automatic t_ref();
    for (int i = 0; i < 17; i++)
    begin
      wr(STEPS[i][33:26], STEPS[i][25:10]);
      cref(STEPS[i][9:0]);
    end
    rd(8'hd5);
    chk(rv, 16'h001f, "margin readback");
  endtask : t_ref

  task automatic t_store();
    wr(8'h22, 16'h0040);
    wr(8'h11, 16'h0000);
    chk(16'(nvmStore), 16'h0001, "store pulse");
    tick(1);
    chk(16'(nvmStore), 16'h0000, "store end");
    chk(16'(nvmTrim), 16'h0040, "stored trim");
  endtask : t_store

  task automatic t_telem();
    feed(1'b0, 12'h064);
    rd(8'h8c);
    chk(rv, 16'h0064, "iout");
    feed(1'b1, 12'h3e8);
    rd(8'h8b);
    chk(rv, 16'h03e8, "vout");
    wr(8'h8c, 16'h0123);
    rd(8'h8c);
    chk(rv, 16'h0064, "read only");
    wr(8'h39, 16'h0005);
    feed(1'b0, 12'h064);
    chk(16'(currentCorrected), 16'h0069, "offset");
    rd(8'h8c);
    chk(rv, 16'h0069, "offset avg");
    wr(8'h39, 16'hff38);
    feed(1'b0, 12'h064);
    chk(16'(currentCorrected), 16'h0000, "sinking");
    rd(8'h8c);
    chk(rv, 16'h0000, "sinking avg");
  endtask : t_telem

  task automatic t_share();
    wr(8'h01, 16'h0080);
    tick(4);
    chk(16'(convEnable), 16'h0001, "on");
    chk(16'(switchEnable), 16'h0001, "switching");
    faultIn = 1'b1;
    tick(1);
    chk(16'(sharedCompFaultLineOeN), 16'h0000, "pull low");
    chk(16'(sharedCompFaultLineOut), 16'h0000, "drive low");
    chk(16'(switchEnable), 16'h0000, "own fault");
    faultIn = 1'b0;
    tick(6);
    chk(16'(switchEnable), 16'h0001, "recovered");
    peerFault = 1'b1;
    tick(6);
    chk(16'(switchEnable), 16'h0000, "peer fault");
    chk(16'(sharedCompFaultLineOeN), 16'h0001, "no pull");
    peerFault = 1'b0;
    wr(8'h01, 16'h0000);
    tick(6);
    chk(16'(switchEnable), 16'h0000, "off");
  endtask : t_share

  task automatic t_sync(input logic s);
    int n;
    slaveStrap = s;
    tick(8);
    n = 0;
    while (phaseLock !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    chk(16'(n < 100), 16'h0001, "lock pulse");
    chk(16'(syncPin), 16'(!s), "lock edge");
  endtask : t_sync

  // three low-side intervals of 20 cycles; the last one is judged
  task automatic t_low();
    int at;
    int hits;
    at = 0;
    hits = 0;
    for (int k = 0; k < 3; k++)
    begin
      lowSideDrive = 1'b0;
      tick(10);
      lowSideDrive = 1'b1;
      hits = 0;
      for (int j = 1; j <= 20; j++)
      begin
        tick(1);
        adcIValid = (sampleCurrent === 1'b1);
        if (sampleCurrent === 1'b1)
        begin
          at = j;
          hits++;
        end
      end
    end
    lowSideDrive = 1'b0;
    adcIValid = 1'b0;
    chk(16'(hits), 16'h0001, "one sample");
    chk(16'(at >= 10 && at <= 14), 16'h0001, "midpoint");
  endtask : t_low

  initial
  begin
    srst = 1'b1;
    cmdWrite = 1'b0;
    cmdRead = 1'b0;
    cmdCode = 8'h00;
    cmdWData = 16'h0000;
    faultIn = 1'b0;
    slaveStrap = 1'b0;
    lowSideDrive = 1'b0;
    adcIValid = 1'b0;
    adcVValid = 1'b0;
    adcIData = 12'h000;
    adcVData = 12'h000;
    peerFault = 1'b0;
    tick(16);
    srst = 1'b0;
    t_reset();
    t_ref();
    t_store();
    t_telem();
    t_share();
    t_sync(1'b0);
    t_sync(1'b1);
    t_low();
    results();
  end
endmodule : tb_ormt_top
